/* rtl/btobx_pkg.sv */
// btobx_pkg: constants and types for the bit invert, overflow branch and skip tail decoder
// assumes: one clock per q phase, four q phases per instruction cycle
package btobx_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;

  // ----------------------------------------------------------------
  // opcode fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_BIT_INVERT = 4'h7;
  localparam logic [3:0] OPC_SKIP_CLR = 4'hb;
  localparam logic [3:0] OPC_SKIP_SET = 4'ha;
  localparam logic [7:0] OPC_BR_OVF = 8'he4;

  // ----------------------------------------------------------------
  // access bank split, pc reset value and pc steps
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_SKIP_ONE = 21'h000004;
  localparam logic [PC_W-1:0] PC_SKIP_TWO = 21'h000006;

  // ----------------------------------------------------------------
  // idle cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] IDLE_NONE = 2'h0;
  localparam logic [1:0] IDLE_ONE = 2'h1;
  localparam logic [1:0] IDLE_TWO = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BTOBX_Q1 = 4'b0001,
    BTOBX_Q2 = 4'b0010,
    BTOBX_Q3 = 4'b0100,
    BTOBX_Q4 = 4'b1000
  } btobx_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rd_en;
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
  } btobx_mem_req_t;

  typedef struct packed {
    logic invert;
    logic branch;
    logic skip_clr;
    logic skip_set;
    logic [2:0] bit_idx;
    logic access_sel;
    logic [7:0] file;
  } btobx_dec_t;

endpackage : btobx_pkg

/* rtl/btobx_core.sv */
// btobx_core: decode and execute of bit invert, branch on overflow and bit test skip tails
// assumes: fetch path presents the word at pc with instr_valid; data memory answers reads combinationally
// Notes on behaviour
// - bit invert decoded from 0111 bbba ffff ffff pattern.
// - only the chosen bit of the addressed byte flips, written back in place.
// - access bit zero uses the fixed access bank, one uses bank select.
// - file address 0..255 in bank; one word, one cycle, flags untouched.
// - taken branch loads pc plus two plus twice the sign extended offset.
// - branch taken only with overflow flag set; no flag modified.
// - taken branch lasts two cycles with an idle one; untaken one cycle.
// - skipping a two word instruction inserts two idle cycles, not one.
// - skip if clear skips on zero bit, runs next instruction on one.
// - bit test takes one, two or three cycles by skip and length.
`timescale 1ns/1ps
`default_nettype none
module btobx_core #(
  parameter int PC_W = btobx_pkg::PC_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic next_two_word,
  input wire logic ovf_flag,
  input wire logic [btobx_pkg::BANK_W-1:0] bank_select_reg,
  input wire logic [btobx_pkg::DATA_W-1:0] mem_rd_data,
  output var btobx_pkg::btobx_mem_req_t mem_req,
  output logic [PC_W-1:0] pc,
  output logic fetch_flush,
  output logic [1:0] idle_left,
  output logic instr_done
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PC_W != btobx_pkg::PC_W) begin : g_bad_width
    $error("btobx_core: pc width must match the package width");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  btobx_pkg::btobx_phase_t phase;
  btobx_pkg::btobx_phase_t next_phase;
  btobx_pkg::btobx_dec_t dec;
  btobx_pkg::btobx_dec_t dec_now;
  logic skip_hit;

  wire in_idle = (idle_left != btobx_pkg::IDLE_NONE);
  assign dec_now.invert = (instr[15:12] == btobx_pkg::OPC_BIT_INVERT);
  assign dec_now.branch = (instr[15:8] == btobx_pkg::OPC_BR_OVF);
  assign dec_now.skip_clr = (instr[15:12] == btobx_pkg::OPC_SKIP_CLR);
  assign dec_now.skip_set = (instr[15:12] == btobx_pkg::OPC_SKIP_SET);
  assign dec_now.bit_idx = instr[11:9];
  assign dec_now.access_sel = instr[8];
  assign dec_now.file = instr[7:0];

  // ----------------------------------------------------------------
  // address, data and decisions
  // ----------------------------------------------------------------
  wire [btobx_pkg::BANK_W-1:0] access_bank = (dec.file < btobx_pkg::ACCESS_SPLIT) ?
    btobx_pkg::ACCESS_LOW_BANK : btobx_pkg::ACCESS_HIGH_BANK;
  wire [btobx_pkg::BANK_W-1:0] eff_bank = dec.access_sel ? bank_select_reg : access_bank;
  wire [btobx_pkg::ADDR_W-1:0] eff_addr = {eff_bank, dec.file};
  wire uses_mem = dec.invert | dec.skip_clr | dec.skip_set;
  wire [btobx_pkg::DATA_W-1:0] bit_mask = 8'h01 << dec.bit_idx;
  wire [btobx_pkg::DATA_W-1:0] toggled = mem_rd_data ^ bit_mask;
  wire tested_bit = mem_rd_data[dec.bit_idx];
  wire next_skip_hit = (dec.skip_clr & ~tested_bit) | (dec.skip_set & tested_bit);
  wire br_taken = dec.branch & ovf_flag;
  wire [PC_W-1:0] br_offset = {{(PC_W-9){dec.file[7]}}, dec.file, 1'b0};
  wire [PC_W-1:0] br_target = pc + btobx_pkg::PC_STEP + br_offset;
  wire [PC_W-1:0] skip_step = next_two_word ? btobx_pkg::PC_SKIP_TWO : btobx_pkg::PC_SKIP_ONE;
  wire [1:0] skip_idle = next_two_word ? btobx_pkg::IDLE_TWO : btobx_pkg::IDLE_ONE;

  // ----------------------------------------------------------------
  // end of cycle results at q4
  // ----------------------------------------------------------------
  wire last_q = (phase == btobx_pkg::BTOBX_Q4);
  wire redirect = ~in_idle & (br_taken | skip_hit);
  wire [PC_W-1:0] next_pc = in_idle ? pc :
    br_taken ? br_target :
    skip_hit ? pc + skip_step : pc + btobx_pkg::PC_STEP;
  wire [1:0] next_idle_left = in_idle ? idle_left - 2'h1 :
    br_taken ? btobx_pkg::IDLE_ONE :
    skip_hit ? skip_idle : btobx_pkg::IDLE_NONE;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (phase)
      btobx_pkg::BTOBX_Q1: next_phase = (in_idle | instr_valid) ? btobx_pkg::BTOBX_Q2 : btobx_pkg::BTOBX_Q1;
      btobx_pkg::BTOBX_Q2: next_phase = btobx_pkg::BTOBX_Q3;
      btobx_pkg::BTOBX_Q3: next_phase = btobx_pkg::BTOBX_Q4;
      btobx_pkg::BTOBX_Q4: next_phase = btobx_pkg::BTOBX_Q1;
      default: next_phase = btobx_pkg::BTOBX_Q1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= btobx_pkg::BTOBX_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // instruction latch, idle cycles zero the decode
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dec <= '0;
    end else if (phase == btobx_pkg::BTOBX_Q1) begin
      dec <= (in_idle | ~instr_valid) ? '0 : dec_now;
    end
  end

  // ----------------------------------------------------------------
  // data memory request: read in q3, write in q4
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_req <= '0;
      skip_hit <= 1'b0;
    end else begin
      case (phase)
        btobx_pkg::BTOBX_Q2: begin
          mem_req.addr <= eff_addr;
          mem_req.rd_en <= uses_mem;
        end
        btobx_pkg::BTOBX_Q3: begin
          mem_req.rd_en <= 1'b0;
          mem_req.wr_en <= dec.invert;
          mem_req.wr_data <= toggled;
          skip_hit <= next_skip_hit;
        end
        btobx_pkg::BTOBX_Q4: begin
          mem_req.wr_en <= 1'b0;
          skip_hit <= 1'b0;
        end
        default: begin
          mem_req.rd_en <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // program counter, flush and idle count
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pc <= btobx_pkg::PC_RESET;
      idle_left <= btobx_pkg::IDLE_NONE;
      fetch_flush <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      fetch_flush <= last_q & redirect;
      instr_done <= last_q & (next_idle_left == btobx_pkg::IDLE_NONE);
      if (last_q) begin
        pc <= next_pc;
        idle_left <= next_idle_left;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_decode_q4;
    last_q && !in_idle;
  endsequence

  sequence s_one_idle_cycle;
    (idle_left == btobx_pkg::IDLE_ONE) [*4] ##1 (idle_left == btobx_pkg::IDLE_NONE);
  endsequence

  a_write_only_invert: assert property (@(posedge clock) disable iff (!rst_n)
    mem_req.wr_en |-> dec.invert && phase == btobx_pkg::BTOBX_Q4)
    else $error("write without bit invert");

  a_write_one_bit: assert property (@(posedge clock) disable iff (!rst_n)
    mem_req.wr_en |-> $countones(mem_req.wr_data ^ $past(mem_rd_data)) == 1)
    else $error("write changed other than one bit");

  a_access_bank_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    mem_req.rd_en && !dec.access_sel |->
    mem_req.addr[11:8] == (dec.file[7] ? btobx_pkg::ACCESS_HIGH_BANK : btobx_pkg::ACCESS_LOW_BANK))
    else $error("access bank address wrong");

  a_bank_select_used: assert property (@(posedge clock) disable iff (!rst_n)
    mem_req.rd_en && dec.access_sel |-> mem_req.addr == {$past(bank_select_reg), dec.file})
    else $error("bank select address wrong");

  a_branch_target_pc: assert property (@(posedge clock) disable iff (!rst_n)
    s_decode_q4 ##0 (dec.branch && ovf_flag) |=>
    pc == $past(pc) + btobx_pkg::PC_STEP + {{(PC_W-9){dec.file[7]}}, dec.file, 1'b0})
    else $error("branch target wrong");

  a_branch_timing: assert property (@(posedge clock) disable iff (!rst_n)
    s_decode_q4 ##0 (dec.branch && ovf_flag) |=> fetch_flush ##0 s_one_idle_cycle)
    else $error("taken branch idle cycle wrong");

  a_branch_untaken: assert property (@(posedge clock) disable iff (!rst_n)
    s_decode_q4 ##0 (dec.branch && !ovf_flag) |=>
    !fetch_flush && instr_done && pc == $past(pc) + btobx_pkg::PC_STEP)
    else $error("untaken branch not one cycle");

  a_skip_two_idle: assert property (@(posedge clock) disable iff (!rst_n)
    s_decode_q4 ##0 (skip_hit && next_two_word) |=>
    idle_left == btobx_pkg::IDLE_TWO && pc == $past(pc) + btobx_pkg::PC_SKIP_TWO)
    else $error("two word skip timing wrong");

  a_skip_clear_sense: assert property (@(posedge clock) disable iff (!rst_n)
    phase == btobx_pkg::BTOBX_Q3 && dec.skip_clr |=> skip_hit == !$past(tested_bit))
    else $error("skip if clear sense wrong");

  a_plain_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    s_decode_q4 ##0 (!skip_hit && !br_taken) |=> idle_left == btobx_pkg::IDLE_NONE && instr_done)
    else $error("non skipping cycle not one cycle");

endmodule : btobx_core
`default_nettype wire

/* verification/btobx_core_tb.sv */
// btobx_core_tb: self-checking bench for the bit invert, overflow branch and skip tail decoder
// assumes: bench plays fetch path and data memory, drives inputs at the falling edge
`timescale 1ns/1ps
`default_nettype none
module btobx_core_tb;
  typedef struct {logic [20:0] pc; int cyc; int fl; int rd;} btobx_note_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic next_two_word = 1'b0;
  logic ovf_flag = 1'b0;
  logic [3:0] bank_select_reg = 4'h0;
  logic [7:0] mem_rd_data;
  btobx_pkg::btobx_mem_req_t mem_req;
  logic [20:0] pc;
  logic fetch_flush;
  logic [1:0] idle_left;
  logic instr_done;
  logic [7:0] mem [0:4095];
  logic [20:0] pc_m = 21'h000000;
  btobx_note_t exp_q[$];
  logic [19:0] exp_wr[$];
  int miscompares = 0;
  int n_tests = 0;
  int cnt = 0;
  int flushes = 0;
  int reads = 0;
  always #10 clock = ~clock;
  assign mem_rd_data = mem[mem_req.addr];
  always @(posedge clock) begin
    cnt <= !rst_n ? 0 : ((instr_done === 1'b1) ? 1 : cnt + 1);
    if (mem_req.wr_en === 1'b1) mem[mem_req.addr] <= mem_req.wr_data;
  end
  btobx_core btobx_core_i (.clock(clock), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
    .next_two_word(next_two_word), .ovf_flag(ovf_flag), .bank_select_reg(bank_select_reg),
    .mem_rd_data(mem_rd_data), .mem_req(mem_req), .pc(pc), .fetch_flush(fetch_flush),
    .idle_left(idle_left), .instr_done(instr_done));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // watcher: compares each result with the oldest note
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    btobx_note_t n;
    if (fetch_flush === 1'b1) begin
      flushes++;
      if (exp_q.size() > 0) check("idle", exp_q[0].cyc - 1, idle_left);
    end
    if (rst_n && mem_req.rd_en !== 1'b0) reads++;
    if (rst_n && mem_req.wr_en !== 1'b0) begin
      if (exp_wr.size() == 0) check("stray write", 0, 1);
      else check("write", exp_wr.pop_front(), {mem_req.addr, mem_req.wr_data});
    end
    if (rst_n && instr_done !== 1'b0) begin
      if (exp_q.size() == 0) check("stray done", 0, 1);
      else begin
        n = exp_q.pop_front();
        check("pc", n.pc, pc);
        check("cycles", n.cyc * 4, cnt);
        check("flush", n.fl, flushes);
        check("reads", n.rd, reads);
      end
      flushes = 0;
      reads = 0;
    end
  end
  // ----------------------------------------------------------------
  // issue one word and wait for its completion
  // ----------------------------------------------------------------
  task automatic issue(input logic [15:0] w, input logic ovf, input logic two);
    logic [11:0] a;
    logic [7:0] d;
    logic skip;
    logic rd;
    btobx_note_t n;
    int k;
    a = w[8] ? {bank_select_reg, w[7:0]} : {(w[7] ? 4'hf : 4'h0), w[7:0]};
    d = mem[a];
    skip = w[12] ? ~d[w[11:9]] : d[w[11:9]];
    rd = (w[15:12] == 4'h7) || (w[15:13] == 3'h5);
    n = '{pc_m + 21'h000002, 1, 0, rd};
    if (w[15:12] == 4'h7) exp_wr.push_back({a, d ^ (8'h01 << w[11:9])});
    else if (w[15:8] == 8'he4 && ovf) n = '{pc_m + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0}, 2, 1, rd};
    else if (w[15:13] == 3'h5 && skip) n = '{pc_m + (two ? 21'h000006 : 21'h000004), two ? 3 : 2, 1, rd};
    exp_q.push_back(n);
    pc_m = n.pc;
    instr = w;
    ovf_flag = ovf;
    next_two_word = two;
    instr_valid = 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clock);
      if (instr_done === 1'b1) break;
    end
    if (k == 40) begin
      miscompares++;
      complete_run();
    end
  endtask : issue
  initial begin
    int i;
    logic [15:0] w;
    logic [7:0] opc [0:4];
    opc = '{8'h70, 8'he4, 8'hb0, 8'ha0, 8'h00};
    void'($urandom(61));
    for (i = 0; i < 4096; i++) mem[i] = 8'($urandom);
    mem[12'h005] = 8'h75;
    repeat (20) @(negedge clock);
    check("reset pc", 0, pc);
    check("reset idle", 0, idle_left);
    rst_n = 1'b1;
    bank_select_reg = 4'h3;
    issue(16'h7805, 1'b1, 1'b0);
    issue(16'h7eff, 1'b0, 1'b0);
    issue(16'h7110, 1'b0, 1'b0);
    issue(16'h7100, 1'b0, 1'b0);
    issue(16'he480, 1'b1, 1'b0);
    issue(16'he47f, 1'b1, 1'b1);
    issue(16'he47f, 1'b0, 1'b0);
    issue(16'hb805, 1'b0, 1'b1);
    issue(16'ha805, 1'b0, 1'b1);
    issue(16'hb005, 1'b0, 1'b0);
    issue(16'ha005, 1'b1, 1'b0);
    issue(16'h0000, 1'b1, 1'b0);
    for (i = 0; i < 80; i++) begin
      w = 16'($urandom);
      w[15:12] = opc[i % 5][7:4];
      if (i % 5 == 1) w[11:8] = 4'h4;
      bank_select_reg = 4'($urandom);
      issue(w, 1'($urandom), 1'($urandom));
    end
    @(negedge clock);
    check("notes left", 0, exp_q.size() + exp_wr.size());
    complete_run();
  end
endmodule : btobx_core_tb
`default_nettype wire
